// ==== shared/rtc_consts.svh ====
// Register offsets, field positions, reset values and rates of the RTC.
// Assumes inclusion by bare name from any file that needs them.
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// Special function register offsets.
`define RTC_OFF_CONFIG 8'ha1
`define RTC_OFF_HUND 8'ha2
`define RTC_OFF_SEC 8'ha3
`define RTC_OFF_MIN 8'ha4
`define RTC_OFF_HOUR 8'ha5
`define RTC_OFF_ALARM_INTERVAL_VALUE 8'ha6
`define RTC_OFF_IRQEN 8'ha9
`define RTC_OFF_KEY 8'hc1
`define RTC_OFF_NOMTRIM 8'hf6
`define RTC_OFF_TEMPTRIM 8'hf7
`define RTC_OFF_PINCFG 8'hff

// Field positions in clock_config_control.
`define RTC_CFG_MIDNIGHT 0
`define RTC_CFG_INTERVAL_TIMER_ENABLE 1
`define RTC_CFG_ALARM 2
`define RTC_CFG_SIT 3
`define RTC_CFG_ITS_LO 4
`define RTC_CFG_WIDE 6
// Field positions in irq_enable_priority_two and int_pin_config.
`define RTC_IRQEN_ETI 2
`define RTC_PIN_CALEN 7
`define RTC_PIN_FSEL_LO 5

// Reset value of every register and the unlock key.
`define RTC_RESET_BYTE 8'h00
`define RTC_KEY 8'hea

// Counter limits.
`define RTC_HUND_MAX 7'h63
`define RTC_MINSEC_MAX 6'h3b
`define RTC_HOUR24_MAX 8'h17
`define RTC_HOUR256_MAX 8'hff

// Crystal rate 32768 Hz; hundredths accumulate by step mod 32768.
`define RTC_XTAL_HZ 32768
`define RTC_HUND_STEP 16'h0064
`define RTC_FAST_RATIO 125
`define RTC_HUND_STEP_FAST 16'h30d4

// Trim: 2 ppm per LSB, sum limited to 248 ppm.
`define RTC_PPM_PER_LSB 2
`define RTC_TRIM_PPM_MAX 248
`define RTC_TRIM_LIMIT 9'sh07c
`define RTC_TRIM_WINDOW 500000

// Calibration phase steps on a 16-bit accumulator: step = 2 * f.
`define RTC_CAL_STEP_1HZ 16'h0002
`define RTC_CAL_STEP_512HZ 16'h0400
`define RTC_CAL_STEP_500HZ 16'h03e8
`define RTC_CAL_STEP_16384HZ 16'h8000

`endif

// ==== shared/rtc_pkg.sv ====
// Types shared by the RTC modules.
// Assumes rtc_consts.svh is not needed here; only types live here.
`default_nettype none
package rtc_pkg;

  // Power state of the host core.
  typedef enum logic [1:0] {
    normal_power_state = 2'b00,
    battery_power_state = 2'b01,
    deep_sleep_state = 2'b10
  } power_state_t;

  // Interval timer timebase choices.
  typedef enum logic [1:0] {
    its_128hz = 2'b00,
    its_second = 2'b01,
    its_minute = 2'b10,
    its_hour = 2'b11
  } its_t;

  // Whole state of the timekeeper.
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sync3;
    logic [7:0] key;
    logic [6:0] hund;
    logic [5:0] sec;
    logic [5:0] min;
    logic [7:0] hour;
    logic [7:0] cfg_shadow;
    logic [7:0] alarm_interval_value_shadow;
    logic wide;
    its_t its;
    logic single_shot_interval;
    logic interval_timer_enable;
    logic midnight;
    logic alarm;
    logic [7:0] alarm_interval_value;
    logic clock_irq_enable;
    logic [7:0] nom;
    logic [7:0] temp;
    logic calen;
    logic [1:0] fsel;
    logic pend;
    logic [14:0] sub_acc;
    logic [7:0] tick128_cnt;
    logic [7:0] ivl_cnt;
    logic ivl_held;
    logic [15:0] cal_acc;
    logic [7:0] rdata;
    logic irq_req;
    logic wake;
    logic cal_out;
    logic cal_oe;
  } rtc_state_t;

endpackage
`default_nettype wire

// ==== shared/rtc_trim_if.sv ====
// Link between the timekeeper and its crystal pulse trimmer.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
`default_nettype none
interface rtc_trim_if;
  logic tick_in; // Raw crystal pulse, one cycle.
  logic signed [8:0] comp; // Saturated correction in 2 ppm units.
  logic tick_out; // Trimmed crystal pulse, one cycle.
  modport core (output tick_in, output comp, input tick_out);
  modport trim (input tick_in, input comp, output tick_out);
endinterface
`default_nettype wire

// ==== core/rtc_trim.sv ====
// Adds or removes crystal pulses to correct the crystal frequency.
// Assumes input pulses are many core cycles apart.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_consts.svh"
module rtc_trim #(
  parameter int WINDOW = `RTC_TRIM_WINDOW
) (
  input wire logic core_clk,
  input wire logic rst,
  rtc_trim_if.trim tr
);
  localparam int WBITS = $clog2(WINDOW);
  // Compare width: wide enough for both the magnitude and the position.
  localparam int CW = (WBITS > 9) ? WBITS : 9;

  // Trimmer state: window position, owed extra pulse, output pulse.
  typedef struct packed {
    logic [WBITS-1:0] win_cnt;
    logic extra;
    logic tick_out;
  } trim_state_t;

  trim_state_t s;
  trim_state_t n;
  logic [8:0] mag; // Magnitude of the correction.
  logic in_slot; // This pulse lies in the corrected part of the window.

  assign tr.tick_out = s.tick_out;

  ////////////////////////////////////////////////////////////////////////
  // One LSB moves one pulse per million-over-two pulses, i.e. 2 ppm.
  // Corrections are spread as the first pulses of each window; the short
  // term jitter this causes is traded for very little logic.
  always_comb begin
    n = s;
    n.tick_out = 1'b0;
    mag = tr.comp[8] ? 9'(-tr.comp) : 9'(tr.comp);
    in_slot = (CW'(mag) > CW'(s.win_cnt));
    if (tr.tick_in) begin
      n.win_cnt = (s.win_cnt == WBITS'(WINDOW - 1)) ? '0 : s.win_cnt + 1'b1;
      if (in_slot && tr.comp[8]) begin
        n.tick_out = 1'b0; // Negative value removes a pulse. [RULE18] [RULE25]
      end else begin
        n.tick_out = 1'b1;
        n.extra = in_slot && (tr.comp != '0); // Positive adds. [RULE19]
      end
    end else if (s.extra) begin
      n.tick_out = 1'b1; // Inserted pulse. [RULE18]
      n.extra = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // A removed pulse never reaches the timekeeper.
  trim_remove_a: assert property (tr.tick_in && tr.comp[8] && in_slot // [RULE18]
    |=> !s.tick_out) else $error("removed pulse passed");
  // An added pulse follows its source pulse by one cycle.
  trim_add_a: assert property (tr.tick_in && !tr.comp[8] && in_slot // [RULE19]
    && tr.comp != '0 |=> s.tick_out ##1 s.tick_out)
    else $error("added pulse missing");
endmodule
`default_nettype wire

// ==== core/rtc_timekeeper.sv ====
// Real-time clock: timekeeping counters, interval alarm, trim, cal pulse.
// Assumes a single-cycle register port from the host core and a raw
// crystal pin that is asynchronous to core_clk.
//
// What this block does
// RULE1: Counters advance from the 32.768 kHz crystal.
// RULE2: Config and interval writes apply on 128Hz tick.
// RULE3: Counter writes need key 0xEA first.
// RULE4: Key clears after any counter write.
// RULE5: Counters keep running during reads.
// RULE6: Software re-reads hundredths to catch carries.
// RULE7: Hours wrap after 23 or 255, day rollover.
// RULE8: Rollover sets flag and pending interrupt.
// RULE9: Rollover or alarm wakes the sleeping core.
// RULE10: One enable gates both interrupt sources.
// RULE11: Pending clears on vector, held while disabled.
// RULE12: Flags stay set until software clears them.
// RULE13: Keep waking until pending interrupt serviced.
// RULE14: Enabled interval counter counts chosen timebase.
// RULE15: Match with interval value raises alarm.
// RULE16: Counter restarts, or holds if single-shot.
// RULE17: Software changes timebase by disable-wait-confirm.
// RULE18: Trim adds/removes pulses, saturated at 248 ppm.
// RULE19: Each trim LSB equals 2 ppm.
// RULE20: Cal out: 00 gives 1Hz, 01 512Hz.
// RULE21: Codes 10 500Hz, 11 16384Hz, active states only; deep sleep refuses only the fast timebase, the cal pin keeps these rates.
// RULE22: Fast modes run the timekeeper 125 times faster.
// RULE23: Both trim registers reset to zero.
// RULE24: Cal enable bit 7, select bits 6-5.
// RULE25: Trim registers are signed two's complement.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_consts.svh"
module rtc_timekeeper #(
  parameter int TRIM_WINDOW = `RTC_TRIM_WINDOW
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic xtal_pin,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic irq_vector_ack,
  input wire rtc_pkg::power_state_t power_state,
  output logic clock_irq_req,
  output logic core_wake,
  output logic cal_pin_out,
  output logic cal_pin_oe
);

  rtc_pkg::rtc_state_t s; // Registered state.
  rtc_pkg::rtc_state_t n; // Next state.
  rtc_trim_if tr (); // Link to the pulse trimmer.

  logic t; // Trimmed crystal pulse.
  logic fast; // Fast calibration timebase in force.
  logic [15:0] sub; // Hundredths accumulator sum.
  logic hund_tick; // One hundredth elapsed.
  logic sec_tick; // One second elapsed.
  logic min_tick; // One minute elapsed.
  logic hour_tick; // One hour elapsed.
  logic tick128; // 128 Hz configuration tick.
  logic [7:0] hour_max; // Last hour before wrap.
  logic midnight_ev; // Day rollover event.
  logic alarm_ev; // Interval match event.
  logic tb_pulse; // Selected interval timebase.
  logic [7:0] ivl_next; // Interval counter plus one.
  logic key_ok; // Key register unlocked.
  logic cnt_wr; // Any write to a counter address.
  logic [8:0] sum; // Raw trim sum.
  logic [15:0] cal_step; // Calibration phase step.
  logic deep; // Core is in the deepest sleep state.

  assign sfr_rdata = s.rdata;
  assign clock_irq_req = s.irq_req;
  assign core_wake = s.wake;
  assign cal_pin_out = s.cal_out;
  assign cal_pin_oe = s.cal_oe;

  ////////////////////////////////////////////////////////////////////////
  // Pulse trimmer sits between the crystal edge and everything counted.
  rtc_trim #(.WINDOW(TRIM_WINDOW)) trim_u (
    .core_clk(core_clk),
    .rst(rst),
    .tr(tr.trim)
  );

  ////////////////////////////////////////////////////////////////////////
  // All next-state logic of the timekeeper.
  always_comb begin
    n = s;
    deep = (power_state == rtc_pkg::deep_sleep_state);
    // Crystal pin through three flops; only sync2 and sync3 feed logic.
    n.sync1 = xtal_pin;
    n.sync2 = s.sync1;
    n.sync3 = s.sync2;
    tr.tick_in = s.sync2 && !s.sync3; // Crystal rising edge. [RULE1]
    // Signed sum of both trim values, clamped to the 248 ppm limit.
    sum = 9'($signed({s.nom[7], s.nom}) + $signed({s.temp[7], s.temp}));
    if ($signed(sum) > `RTC_TRIM_LIMIT) begin
      tr.comp = `RTC_TRIM_LIMIT; // [RULE18] [RULE25]
    end else if ($signed(sum) < -`RTC_TRIM_LIMIT) begin
      tr.comp = -`RTC_TRIM_LIMIT; // [RULE18]
    end else begin
      tr.comp = $signed(sum);
    end
    t = tr.tick_out;
    // Fast modes are refused in deep sleep; the slow path then runs.
    fast = s.fsel[1] && !deep; // [RULE21] [RULE22]

    // Hundredths come from a fractional accumulator, since 32768 Hz is
    // not a multiple of 100; fast mode steps 125 times as far.
    sub = {1'b0, s.sub_acc} +
      (fast ? `RTC_HUND_STEP_FAST : `RTC_HUND_STEP); // [RULE22]
    hund_tick = t && sub[15];
    if (t) begin
      n.sub_acc = sub[14:0];
      n.tick128_cnt = s.tick128_cnt + 8'h01;
    end
    tick128 = t && (s.tick128_cnt == 8'hff);

    // Counter chain; reads have no side effect, so it never pauses.
    hour_max = s.wide ? `RTC_HOUR256_MAX : `RTC_HOUR24_MAX; // [RULE5]
    sec_tick = hund_tick && (s.hund == `RTC_HUND_MAX);
    min_tick = sec_tick && (s.sec == `RTC_MINSEC_MAX);
    hour_tick = min_tick && (s.min == `RTC_MINSEC_MAX);
    midnight_ev = hour_tick && (s.hour == hour_max); // [RULE7]
    if (hund_tick) begin
      n.hund = sec_tick ? 7'h00 : s.hund + 7'h01; // [RULE1]
    end
    if (sec_tick) begin
      n.sec = min_tick ? 6'h00 : s.sec + 6'h01;
    end
    if (min_tick) begin
      n.min = hour_tick ? 6'h00 : s.min + 6'h01;
    end
    if (hour_tick) begin
      n.hour = midnight_ev ? 8'h00 : s.hour + 8'h01; // [RULE7]
    end

    // Locked counter writes; a direct write beats the running count.
    key_ok = (s.key == `RTC_KEY);
    cnt_wr = sfr_wr && (sfr_addr == `RTC_OFF_HUND ||
      sfr_addr == `RTC_OFF_SEC || sfr_addr == `RTC_OFF_MIN ||
      sfr_addr == `RTC_OFF_HOUR);
    if (sfr_wr && key_ok) begin
      case (sfr_addr)
        `RTC_OFF_HUND: n.hund = sfr_wdata[6:0]; // [RULE3]
        `RTC_OFF_SEC: n.sec = sfr_wdata[5:0]; // [RULE3]
        `RTC_OFF_MIN: n.min = sfr_wdata[5:0]; // [RULE3]
        `RTC_OFF_HOUR: n.hour = sfr_wdata; // [RULE3]
        default: n.hund = n.hund;
      endcase
    end
    if (sfr_wr && sfr_addr == `RTC_OFF_KEY) begin
      n.key = sfr_wdata;
    end else if (cnt_wr) begin
      n.key = `RTC_RESET_BYTE; // Relock after every counter write. [RULE4]
    end

    // Host writes to the plain registers.
    if (sfr_wr) begin
      case (sfr_addr)
        `RTC_OFF_CONFIG: n.cfg_shadow = sfr_wdata;
        `RTC_OFF_ALARM_INTERVAL_VALUE: n.alarm_interval_value_shadow = sfr_wdata;
        `RTC_OFF_IRQEN: n.clock_irq_enable = sfr_wdata[`RTC_IRQEN_ETI];
        `RTC_OFF_NOMTRIM: n.nom = sfr_wdata;
        `RTC_OFF_TEMPTRIM: n.temp = sfr_wdata;
        `RTC_OFF_PINCFG: begin
          n.calen = sfr_wdata[`RTC_PIN_CALEN]; // [RULE24]
          n.fsel = sfr_wdata[`RTC_PIN_FSEL_LO +: 2]; // [RULE24]
        end
        default: n.clock_irq_enable = n.clock_irq_enable;
      endcase
    end

    // Config reaches the timekeeper only on the 128 Hz tick, so the
    // readback of interval_timer_enable lags a write by up to one tick.
    if (tick128) begin
      n.wide = s.cfg_shadow[`RTC_CFG_WIDE]; // [RULE2]
      n.its = rtc_pkg::its_t'(s.cfg_shadow[`RTC_CFG_ITS_LO +: 2]);
      n.single_shot_interval = s.cfg_shadow[`RTC_CFG_SIT];
      n.interval_timer_enable = s.cfg_shadow[`RTC_CFG_INTERVAL_TIMER_ENABLE];
      n.alarm_interval_value = s.alarm_interval_value_shadow; // [RULE2]
    end

    // Interval timer on the chosen timebase.
    unique case (s.its)
      rtc_pkg::its_128hz: tb_pulse = tick128;
      rtc_pkg::its_second: tb_pulse = sec_tick;
      rtc_pkg::its_minute: tb_pulse = min_tick;
      rtc_pkg::its_hour: tb_pulse = hour_tick;
    endcase
    ivl_next = s.ivl_cnt + 8'h01;
    alarm_ev = 1'b0;
    if (!s.interval_timer_enable) begin
      n.ivl_cnt = 8'h00;
      n.ivl_held = 1'b0;
    end else if (s.ivl_held) begin
      n.ivl_cnt = 8'h00; // Single shot stays in reset. [RULE16]
    end else if (tb_pulse) begin
      if (ivl_next == s.alarm_interval_value) begin
        alarm_ev = 1'b1; // [RULE15]
        n.ivl_cnt = 8'h00; // [RULE16]
        n.ivl_held = s.single_shot_interval; // [RULE16]
      end else begin
        n.ivl_cnt = ivl_next; // [RULE14]
      end
    end

    // Flags: a zero written clears, an event in the same cycle wins.
    if (sfr_wr && sfr_addr == `RTC_OFF_CONFIG) begin
      n.midnight = s.midnight && sfr_wdata[`RTC_CFG_MIDNIGHT];
      n.alarm = s.alarm && sfr_wdata[`RTC_CFG_ALARM];
    end
    if (midnight_ev) begin
      n.midnight = 1'b1; // [RULE8] [RULE12]
    end
    if (alarm_ev) begin
      n.alarm = 1'b1; // [RULE15] [RULE12]
    end

    // Pending interrupt: vectoring clears, a new event wins.
    if (irq_vector_ack) begin
      n.pend = 1'b0; // [RULE11]
    end
    if (midnight_ev || alarm_ev) begin
      n.pend = 1'b1; // [RULE8] [RULE15]
    end
    n.irq_req = n.pend && n.clock_irq_enable; // [RULE10] [RULE11]
    // Wake follows pending, so an unserviced event re-wakes each time.
    n.wake = n.pend && deep; // [RULE9] [RULE13]

    // Calibration output from a phase accumulator on trimmed pulses.
    unique case (s.fsel)
      2'b00: cal_step = `RTC_CAL_STEP_1HZ; // [RULE20]
      2'b01: cal_step = `RTC_CAL_STEP_512HZ; // [RULE20]
      2'b10: cal_step = `RTC_CAL_STEP_500HZ; // [RULE21]
      2'b11: cal_step = `RTC_CAL_STEP_16384HZ; // [RULE21]
    endcase
    if (t) begin
      n.cal_acc = s.cal_acc + cal_step;
    end
    n.cal_out = s.calen && s.cal_acc[15]; // [RULE20]
    n.cal_oe = s.calen; // [RULE20]

    // Read data: one cycle after the address, unmapped reads as zero.
    n.rdata = 8'h00;
    case (sfr_addr)
      `RTC_OFF_CONFIG: begin
        n.rdata[`RTC_CFG_WIDE] = s.wide;
        n.rdata[`RTC_CFG_ITS_LO +: 2] = s.its;
        n.rdata[`RTC_CFG_SIT] = s.single_shot_interval;
        n.rdata[`RTC_CFG_ALARM] = s.alarm;
        n.rdata[`RTC_CFG_INTERVAL_TIMER_ENABLE] = s.interval_timer_enable;
        n.rdata[`RTC_CFG_MIDNIGHT] = s.midnight;
      end
      `RTC_OFF_HUND: n.rdata = {1'b0, s.hund};
      `RTC_OFF_SEC: n.rdata = {2'b00, s.sec};
      `RTC_OFF_MIN: n.rdata = {2'b00, s.min};
      `RTC_OFF_HOUR: n.rdata = s.hour;
      `RTC_OFF_ALARM_INTERVAL_VALUE: n.rdata = s.alarm_interval_value;
      `RTC_OFF_IRQEN: n.rdata[`RTC_IRQEN_ETI] = s.clock_irq_enable;
      `RTC_OFF_KEY: n.rdata = s.key;
      `RTC_OFF_NOMTRIM: n.rdata = s.nom;
      `RTC_OFF_TEMPTRIM: n.rdata = s.temp;
      `RTC_OFF_PINCFG: begin
        n.rdata[`RTC_PIN_CALEN] = s.calen;
        n.rdata[`RTC_PIN_FSEL_LO +: 2] = s.fsel;
      end
      default: n.rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; every reset source clears the trim values too.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s <= '0; // [RULE23]
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Any counter write relocks the key.
  key_relock_a: assert property (cnt_wr |=> s.key == 8'h00) // [RULE4]
    else $error("key not cleared after counter write");
  // Locked hour write leaves the hour alone.
  locked_hour_a: assert property (sfr_wr && sfr_addr == `RTC_OFF_HOUR // [RULE3]
    && !key_ok && !hour_tick |=> s.hour == $past(s.hour))
    else $error("locked hour write took effect");
  // Unlocked seconds write lands.
  unlocked_sec_a: assert property (sfr_wr && sfr_addr == `RTC_OFF_SEC // [RULE3]
    && key_ok |=> s.sec == $past(sfr_wdata[5:0]))
    else $error("unlocked seconds write lost");
  // Day rollover wraps the hour and raises flag and pending.
  hour_wrap_a: assert property (hour_tick && !s.wide // [RULE7]
    && s.hour == 8'h17 && !(sfr_wr && key_ok)
    |=> s.hour == 8'h00 && s.midnight && s.pend)
    else $error("day rollover wrong");
  // Pending holds until vectored.
  pend_hold_a: assert property (s.pend && !irq_vector_ack // [RULE11]
    |=> s.pend ##1 (s.pend || $past(irq_vector_ack)))
    else $error("pending dropped without vector");
  // Request is the pending flag gated by the enable.
  irq_gate_a: assert property (clock_irq_req == (s.pend && s.clock_irq_enable)) // [RULE10]
    else $error("interrupt request not gated by enable");
  // Deep sleep with pending keeps waking.
  wake_keep_a: assert property (s.pend && !irq_vector_ack && deep // [RULE13]
    |=> core_wake) else $error("no re-wake while pending");
  // Config lands on the tick.
  cfg_sync_a: assert property (tick128 // [RULE2]
    |=> s.interval_timer_enable == $past(s.cfg_shadow[`RTC_CFG_INTERVAL_TIMER_ENABLE])
    && s.alarm_interval_value == $past(s.alarm_interval_value_shadow))
    else $error("config not transferred on tick");
  // Single shot holds the interval counter after an alarm.
  single_shot_a: assert property (alarm_ev && s.single_shot_interval // [RULE16]
    |=> s.ivl_held && s.ivl_cnt == 8'h00 && s.alarm)
    else $error("single shot did not hold");
  // Trim correction never exceeds its limit.
  trim_limit_a: assert property (tr.comp <= `RTC_TRIM_LIMIT // [RULE18]
    && tr.comp >= -`RTC_TRIM_LIMIT) else $error("trim not saturated");
  // Cal pin driven the cycle after it is enabled.
  cal_enable_a: assert property (s.calen |=> cal_pin_oe) // [RULE20]
    else $error("cal pin not driven");
endmodule
`default_nettype wire

// ==== tb/rtc_core_model.sv ====
// Host core model: the crystal source and the core's interrupt vectoring.
// Assumes the timekeeper's core_clk and rst; the bench steers it by serve.
`timescale 1ns/100ps
`default_nettype none
module rtc_core_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic serve,
  input wire logic clock_irq_req,
  output logic xtal_pin,
  output logic irq_vector_ack
);
  ////////////////////////////////////////////////////////////////////////////
  // The crystal runs free, sped up to 16 core cycles a period so that the
  // carries and ticks arrive within a short run.
  initial begin
    xtal_pin = 1'b0;
    forever #64 xtal_pin = ~xtal_pin;
  end

  ////////////////////////////////////////////////////////////////////////////
  // While serve is high the core vectors to an enabled request once.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_vector_ack <= 1'b0;
    end else begin
      irq_vector_ack <= serve & clock_irq_req & ~irq_vector_ack;
    end
  end
endmodule
`default_nettype wire

// ==== tb/rtc_timekeeping_alarm_calibration_test.sv ====
// Self-checking bench for the timekeeper through its register port.
// Assumes the partner model supplies the crystal and interrupt vectoring.
`timescale 1ns/100ps
`default_nettype none
module rtc_timekeeping_alarm_calibration_test;
  logic core_clk, rst, sfr_wr, serve, xtal_pin, irq_vector_ack;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d, h0, h1;
  rtc_pkg::power_state_t power_state;
  logic clock_irq_req, core_wake, cal_pin_out, cal_pin_oe;
  int fail_count, n_compared, i, n;
  int lo[4] = '{0, 2, 2, 95}; // Expected pulse rises per select code.
  int hi[4] = '{1, 4, 4, 105};
  int hlo[4] = '{0, 0, 70, 70}; // Hundredths advanced in the same span.
  int hhi[4] = '{1, 1, 84, 84};

  // A short trim window keeps corrections visible in a brief run.
  rtc_timekeeper #(.TRIM_WINDOW(1000)) rtc_timekeeper_inst (
    .core_clk(core_clk), .rst(rst), .xtal_pin(xtal_pin),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .irq_vector_ack(irq_vector_ack),
    .power_state(power_state), .clock_irq_req(clock_irq_req),
    .core_wake(core_wake), .cal_pin_out(cal_pin_out),
    .cal_pin_oe(cal_pin_oe));
  rtc_core_model rtc_core_model_inst (
    .core_clk(core_clk), .rst(rst), .serve(serve),
    .clock_irq_req(clock_irq_req), .xtal_pin(xtal_pin),
    .irq_vector_ack(irq_vector_ack));

  ////////////////////////////////////////////////////////////////////////////
  // The 125 MHz core clock.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks; an unknown never passes, by case inequality in check8 and $isunknown in check_range.
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Got is a vector so that an unknown read value is not hidden as zero.
  task automatic check_range(input logic [31:0] got, input int lo_v,
    input int hi_v);
    n_compared++;
    if ($isunknown(got) || got < lo_v || got > hi_v) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo_v, hi_v);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Register port cycles: a one-cycle write strobe, a one-cycle read lag.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    #1 sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(posedge core_clk);
    #1 sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    #1 sfr_addr = a;
    @(posedge core_clk);
    #1 v = sfr_rdata;
  endtask
  // Every counter write is preceded by a fresh unlock key.
  task automatic set_time(input logic [7:0] hr, input logic [7:0] ms);
    wr(8'hc1, 8'hea);
    wr(8'ha5, hr);
    wr(8'hc1, 8'hea);
    wr(8'ha4, ms);
    wr(8'hc1, 8'hea);
    wr(8'ha3, ms);
    wr(8'hc1, 8'hea);
    wr(8'ha2, 8'h63);
  endtask
  // Bounded wait for the request (w=0) or the wake line (w=1) to reach lvl.
  task automatic wait_on(input int w, input logic lvl);
    for (int k = 0; k < 30000; k++) begin
      @(posedge core_clk);
      #1;
      if ((w == 0 ? clock_irq_req : core_wake) === lvl) break;
    end
    check8({7'h00, (w == 0 ? clock_irq_req : core_wake)}, {7'h00, lvl});
  endtask

  // One place where the run ends.
  task automatic summarize;
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the tests need about 80k cycles; 760 us is 95k cycles.
  initial begin
    #760000;
    fail_count++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    rst = 1'b1;
    sfr_wr = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    serve = 1'b0;
    power_state = rtc_pkg::normal_power_state;
    fail_count = 0;
    n_compared = 0;
    repeat (10) @(posedge core_clk);
    #1 rst = 1'b0;
    rd(8'hf6, d); check8(d, 8'h00);
    rd(8'hf7, d); check8(d, 8'h00);
    wr(8'hf7, 8'hfe); rd(8'hf7, d); check8(d, 8'hfe);
    rd(8'h80, d); check8(d, 8'h00);
    wr(8'ha3, 8'h1e); rd(8'ha3, d); check8(d, 8'h00);
    wr(8'hc1, 8'hea); wr(8'ha3, 8'h1e);
    rd(8'ha3, d); check8(d, 8'h1e);
    wr(8'ha3, 8'h2a); rd(8'ha3, d); check8(d, 8'h1e);
    // Day rollover from 23:59:59.99 with the interrupt enabled.
    wr(8'ha9, 8'h04);
    set_time(8'h17, 8'h3b);
    wait_on(0, 1'b1);
    rd(8'ha5, d); check8(d, 8'h00);
    // Carry-safe read: repeat while hundredths moved under the read.
    do begin
      rd(8'ha2, h0);
      rd(8'ha3, d);
      rd(8'ha2, h1);
    end while (h1 !== h0);
    check8(d, 8'h00);
    rd(8'ha1, d); check8(d & 8'h01, 8'h01);
    serve = 1'b1;
    wait_on(0, 1'b0);
    rd(8'ha1, d); check8(d & 8'h01, 8'h01);
    wr(8'ha1, 8'h00); rd(8'ha1, d); check8(d & 8'h01, 8'h00);
    // Rollover in deep sleep with the enable off: stays pending, wakes.
    serve = 1'b0;
    wr(8'ha9, 8'h00);
    power_state = rtc_pkg::deep_sleep_state;
    set_time(8'h17, 8'h3b);
    wait_on(1, 1'b1);
    repeat (50) @(posedge core_clk);
    #1 check8({7'h00, core_wake}, 8'h01);
    check8({7'h00, clock_irq_req}, 8'h00);
    serve = 1'b1;
    wr(8'ha9, 8'h04);
    wait_on(0, 1'b1);
    wait_on(1, 1'b0);
    power_state = rtc_pkg::normal_power_state;
    // Wide hour range takes effect within two ticks.
    wr(8'ha1, 8'h40);
    repeat (9000) @(posedge core_clk);
    rd(8'ha1, d); check8(d & 8'h40, 8'h40);
    set_time(8'h17, 8'h3b);
    repeat (8000) @(posedge core_clk);
    rd(8'ha5, d); check8(d, 8'h18);
    set_time(8'hff, 8'h3b);
    repeat (8000) @(posedge core_clk);
    rd(8'ha5, d); check8(d, 8'h00);
    rd(8'ha1, d); check8(d & 8'h01, 8'h01);
    // A small positive trim sum from here on, so pulses are also added.
    wr(8'hf6, 8'h03);
    rd(8'hf6, d);
    check8(d, 8'h03);
    // Single-shot alarm after two 128 Hz pulses.
    wr(8'ha6, 8'h02);
    repeat (4200) @(posedge core_clk);
    wr(8'ha1, 8'h4a);
    d = 8'h00;
    for (i = 0; i < 12000 && d[2] !== 1'b1; i++) rd(8'ha1, d);
    check8(d & 8'h04, 8'h04);
    check_range(i, 1500, 11999);
    wr(8'ha1, 8'h4a);
    repeat (13000) @(posedge core_clk);
    rd(8'ha1, d); check8(d & 8'h04, 8'h00);
    // Calibration output, every select code, over 200 crystal pulses.
    for (int c = 0; c < 4; c++) begin
      wr(8'hff, {1'b1, c[1:0], 5'h00});
      rd(8'hff, d);
      check8(d, {1'b1, c[1:0], 5'h00});
      rd(8'ha2, h0);
      check8({7'h00, cal_pin_oe}, 8'h01);
      n = 0;
      d[0] = cal_pin_out;
      repeat (3200) begin
        @(posedge core_clk);
        #1 if (cal_pin_out === 1'b1 && d[0] === 1'b0) n++;
        d[0] = cal_pin_out;
      end
      rd(8'ha2, h1);
      check_range(n, lo[c], hi[c]);
      check_range((h1 + 8'h64 - h0) % 8'h64, hlo[c], hhi[c]);
    end
    wr(8'hff, 8'h00);
    rd(8'hff, d); check8({6'h00, d[7], cal_pin_oe}, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
